// File: verilog/adcctl_pkg.sv
// Package: constants, register map and carrier types of the converter control
// Behaviour
// - Upper disable bits switch off pins 7-10 buffers
// - Disabled pin reads zero in port value
// - Converter yields 10-bit code, ground to reference
// - Three-bit reference select split across two registers
// - Six-bit channel field picks eleven single-ended pins
// - Differential gain from channel and gain bit
// - Channel code 111111 selects temperature sensor
// - Selections inactive and no power while disabled
// - Result right-aligned, left-aligned when bit set
// - Low read locks results, high read unlocks
// - Completion while locked discards the new result
// - Completion raises the conversion-done interrupt
// - Interrupt raised even when result discarded
// - Start bit begins conversion, reads one until done
// - Normal conversion 13 cycles, first one 25
// - Prescaler runs only while converter enabled
// - Selections tracked until start, frozen until last
package adcctl_pkg;

  localparam int          ADDR_W = 10;
  localparam int          DATA_W = 8;
  localparam int          RES_W  = 10;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_INPUT_DISABLE = 8'h02;
  localparam logic [7:0]  IDX_CONTROL_B     = 8'h03;
  localparam logic [7:0]  IDX_RESULT_LOW    = 8'h04;
  localparam logic [7:0]  IDX_RESULT_HIGH   = 8'h05;
  localparam logic [7:0]  IDX_CONTROL_A     = 8'h06;
  localparam logic [7:0]  IDX_CHANNEL_SEL   = 8'h07;
  localparam logic [7:0]  IDX_PORT_LEVEL    = 8'h09;

  // Control A fields
  localparam int          CA_ENABLE   = 7;
  localparam int          CA_START    = 6;
  localparam int          CA_DONE     = 4;
  localparam int          CA_IRQ_EN   = 3;
  localparam int          CA_PRESC_HI = 2;
  // Channel select fields
  localparam int          CS_REF_HI   = 7;
  localparam int          CS_REF_LO   = 6;
  localparam int          CS_LEFT     = 5;
  localparam int          CS_CH_HI    = 4;
  // Control B fields
  localparam int          CB_GAIN     = 6;
  localparam int          CB_REF2     = 4;
  localparam int          CB_CH5      = 3;
  // Input disable: pins 7..10 on bits 7:4
  localparam int          DIS_LO      = 4;
  localparam int          PIN_N       = 4;

  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [5:0]  CH_TEMP       = 6'h3F;
  localparam logic [5:0]  CH_SINGLE_MAX = 6'h0A;
  localparam logic [4:0]  CONV_NORMAL   = 5'd13;
  localparam logic [4:0]  CONV_FIRST    = 5'd25;
  localparam int          PRESC_W       = 8;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  localparam logic        HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PENDING,
    ST_CONVERT,
    ST_WAIT_DONE
  } adcctl_state_t;

  // Request toward the analog core
  typedef struct packed {
    logic             enable;
    logic             clk_tick;
    logic             start;
    logic             first;
    logic             sample_end;
    logic [2:0]       reference;
    logic [5:0]       channel;
    logic             gain_range;
    logic             gain_bypass;
    logic             temp_sensor;
  } adcctl_core_req_t;

  // Answer from the analog core
  typedef struct packed {
    logic             done;
    logic [RES_W-1:0] result;
  } adcctl_core_rsp_t;

endpackage

// File: verilog/adcctl_top.sv
// Converter control: AHB-Lite registers, sequencing and result lock
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
module adcctl_top #(
  parameter int PRESC_W = adcctl_pkg::PRESC_W
) (
  // Clock and reset
  input  wire  logic                              hclk,
  input  wire  logic                              hresetn,
  // AHB-Lite slave
  input  wire  logic                              hsel,
  input  wire  logic [adcctl_pkg::ADDR_W-1:0]     haddr,
  input  wire  logic [1:0]                        htrans,
  input  wire  logic                              hwrite,
  input  wire  logic [2:0]                        hsize,
  input  wire  logic [31:0]                       hwdata,
  input  wire  logic                              hready,
  output logic       [31:0]                       hrdata,
  output logic                                    hreadyout,
  output logic                                    hresp,
  // Analog core
  output adcctl_pkg::adcctl_core_req_t            core_req,
  input  wire  adcctl_pkg::adcctl_core_rsp_t      core_rsp,
  // Pins and interrupt
  input  wire  logic [adcctl_pkg::PIN_N-1:0]      pin_level,
  output logic       [adcctl_pkg::PIN_N-1:0]      pin_buffer_off_bits,
  output logic                                    conversion_irq
);

  logic [7:0]                  input_disable_reg;
  logic                        converter_enable_reg;
  logic                        irq_enable_reg;
  logic [2:0]                  prescale_reg;
  logic                        conversion_done_flag_reg;
  logic [2:0]                  reference_select_reg;
  logic [5:0]                  channel_gain_select_reg;
  logic                        gain_range_select_reg;
  logic                        result_left_align_reg;
  logic [adcctl_pkg::RES_W-1:0] result_reg;
  logic                        result_lock_reg;
  logic [PRESC_W-1:0]          presc_reg;
  logic [4:0]                  cycle_reg;
  logic                        first_reg;
  logic                        frozen_reg;
  logic [2:0]                  ref_live_reg;
  logic [5:0]                  ch_live_reg;
  logic                        gain_live_reg;
  logic [adcctl_pkg::PIN_N-1:0] pin_meta_reg;
  logic [adcctl_pkg::PIN_N-1:0] pin_sync_reg;
  logic                        dwr_reg;
  logic [7:0]                  didx_reg;
  adcctl_pkg::adcctl_state_t   state_reg;

  logic                        a_valid;
  logic [7:0]                  a_idx;
  logic                        rd_low;
  logic                        rd_high;
  logic [7:0]                  wd;
  logic                        wr_ca;
  logic                        wr_cs;
  logic                        wr_cb;
  logic                        tick;
  logic                        done_evt;
  logic [4:0]                  conv_len;
  logic [15:0]                 aligned;
  logic [7:0]                  rd_val;
  logic [PRESC_W-1:0]          presc_mask;
  logic [7:0]                  ca_val;
  logic                        start_wr;

  assign a_valid = hsel && hready
                   && (htrans == adcctl_pkg::HTRANS_NONSEQ);
  assign a_idx   = haddr[9:2];
  assign rd_low  = a_valid && !hwrite
                   && (a_idx == adcctl_pkg::IDX_RESULT_LOW);
  assign rd_high = a_valid && !hwrite
                   && (a_idx == adcctl_pkg::IDX_RESULT_HIGH);
  assign wd      = hwdata[7:0];
  assign wr_ca   = dwr_reg && (didx_reg == adcctl_pkg::IDX_CONTROL_A);
  assign wr_cs   = dwr_reg && (didx_reg == adcctl_pkg::IDX_CHANNEL_SEL);
  assign wr_cb   = dwr_reg && (didx_reg == adcctl_pkg::IDX_CONTROL_B);
  assign done_evt = (state_reg == adcctl_pkg::ST_WAIT_DONE)
                    && core_rsp.done;
  assign conv_len = first_reg ? adcctl_pkg::CONV_FIRST
                              : adcctl_pkg::CONV_NORMAL;
  assign start_wr = wr_ca && wd[adcctl_pkg::CA_START]
                    && wd[adcctl_pkg::CA_ENABLE];

  // Divide by two to the power of (prescale + 1)
  // The counter needs eight bits to reach the largest divisor
  assign presc_mask = PRESC_W'((2 << prescale_reg) - 1);
  assign tick = converter_enable_reg
                && ((presc_reg & presc_mask) == presc_mask);

  // Result alignment in the two byte registers
  always_comb begin
    if (result_left_align_reg) begin
      aligned = {result_reg, 6'h00};
    end else begin
      aligned = {6'h00, result_reg};
    end
  end

  always_comb begin
    ca_val = adcctl_pkg::RESET_BYTE;
    ca_val[adcctl_pkg::CA_ENABLE] = converter_enable_reg;
    ca_val[adcctl_pkg::CA_START]  = (state_reg != adcctl_pkg::ST_IDLE);
    ca_val[adcctl_pkg::CA_DONE]   = conversion_done_flag_reg;
    ca_val[adcctl_pkg::CA_IRQ_EN] = irq_enable_reg;
    ca_val[adcctl_pkg::CA_PRESC_HI:0] = prescale_reg;
  end

  always_comb begin
    case (a_idx)
      adcctl_pkg::IDX_INPUT_DISABLE: rd_val = input_disable_reg;
      adcctl_pkg::IDX_CONTROL_A:     rd_val = ca_val;
      adcctl_pkg::IDX_CHANNEL_SEL:   rd_val = {reference_select_reg[1:0],
                                               result_left_align_reg,
                                               channel_gain_select_reg[4:0]};
      adcctl_pkg::IDX_CONTROL_B:     rd_val = {1'b0, gain_range_select_reg,
                                               1'b0, reference_select_reg[2],
                                               channel_gain_select_reg[5],
                                               3'b000};
      adcctl_pkg::IDX_RESULT_LOW:    rd_val = aligned[7:0];
      adcctl_pkg::IDX_RESULT_HIGH:   rd_val = aligned[15:8];
      adcctl_pkg::IDX_PORT_LEVEL:    rd_val = {pin_sync_reg
                                      & ~input_disable_reg[7:4], 4'h0};
      default:                       rd_val = adcctl_pkg::RESET_BYTE;
    endcase
  end

  // Bus slave: zero wait states, read data captured at the address phase
  // A read pipelined right behind a write still sees the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dwr_reg   <= 1'b0;
      didx_reg  <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= adcctl_pkg::HRESP_OKAY;
    end else begin
      dwr_reg   <= a_valid && hwrite;
      didx_reg  <= a_idx;
      hreadyout <= 1'b1;
      hresp     <= adcctl_pkg::HRESP_OKAY;
      if (a_valid && !hwrite) begin
        hrdata <= {24'h00_0000, rd_val};
      end
    end
  end

  // Input disable register and pad control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_disable_reg   <= adcctl_pkg::RESET_BYTE;
      pin_buffer_off_bits <= 4'h0;
    end else begin
      if (dwr_reg && (didx_reg == adcctl_pkg::IDX_INPUT_DISABLE)) begin
        input_disable_reg <= {wd[7:4], 4'h0};
      end
      pin_buffer_off_bits <= input_disable_reg[7:4];
    end
  end

  // Pin level synchroniser
  // Pins are asynchronous; two flops guard against metastability
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= pin_level;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Control and selection registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      converter_enable_reg    <= 1'b0;
      irq_enable_reg          <= 1'b0;
      prescale_reg            <= 3'h0;
      reference_select_reg    <= 3'h0;
      channel_gain_select_reg <= 6'h00;
      gain_range_select_reg   <= 1'b0;
      result_left_align_reg   <= 1'b0;
    end else begin
      if (wr_ca) begin
        converter_enable_reg <= wd[adcctl_pkg::CA_ENABLE];
        irq_enable_reg       <= wd[adcctl_pkg::CA_IRQ_EN];
        prescale_reg         <= wd[adcctl_pkg::CA_PRESC_HI:0];
      end
      if (wr_cs) begin
        reference_select_reg[1:0]    <= wd[adcctl_pkg::CS_REF_HI:
                                           adcctl_pkg::CS_REF_LO];
        result_left_align_reg        <= wd[adcctl_pkg::CS_LEFT];
        channel_gain_select_reg[4:0] <= wd[adcctl_pkg::CS_CH_HI:0];
      end
      if (wr_cb) begin
        reference_select_reg[2]    <= wd[adcctl_pkg::CB_REF2];
        channel_gain_select_reg[5] <= wd[adcctl_pkg::CB_CH5];
        gain_range_select_reg      <= wd[adcctl_pkg::CB_GAIN];
      end
    end
  end

  // Prescaler held in reset while the converter is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_reg <= '0;
    end else if (!converter_enable_reg) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + 1'b1;
    end
  end

  // Conversion sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= adcctl_pkg::ST_IDLE;
      cycle_reg <= 5'd0;
      first_reg <= 1'b0;
      frozen_reg <= 1'b0;
    end else if (!converter_enable_reg) begin
      // Disabling aborts any conversion; next one is a first conversion.
      // Enable and start often come in one write, so keep that start.
      if (start_wr) begin
        state_reg <= adcctl_pkg::ST_PENDING;
      end else begin
        state_reg <= adcctl_pkg::ST_IDLE;
      end
      cycle_reg  <= 5'd0;
      first_reg  <= 1'b1;
      frozen_reg <= 1'b0;
    end else begin
      case (state_reg)
        adcctl_pkg::ST_IDLE: begin
          if (start_wr) begin
            state_reg <= adcctl_pkg::ST_PENDING;
          end
        end
        adcctl_pkg::ST_PENDING: begin
          if (tick) begin
            state_reg  <= adcctl_pkg::ST_CONVERT;
            cycle_reg  <= 5'd1;
            frozen_reg <= 1'b1;
          end
        end
        adcctl_pkg::ST_CONVERT: begin
          if (tick) begin
            cycle_reg <= cycle_reg + 5'd1;
            if (cycle_reg == conv_len - 5'd1) begin
              frozen_reg <= 1'b0;
            end
            if (cycle_reg == conv_len) begin
              state_reg <= adcctl_pkg::ST_WAIT_DONE;
              first_reg <= 1'b0;
            end
          end
        end
        adcctl_pkg::ST_WAIT_DONE: begin
          if (core_rsp.done) begin
            state_reg <= adcctl_pkg::ST_IDLE;
          end
        end
        default: state_reg <= adcctl_pkg::ST_IDLE;
      endcase
    end
  end

  // Live selections follow the registers except while frozen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_live_reg  <= 3'h0;
      ch_live_reg   <= 6'h00;
      gain_live_reg <= 1'b0;
    end else if (!frozen_reg) begin
      ref_live_reg  <= reference_select_reg;
      ch_live_reg   <= channel_gain_select_reg;
      gain_live_reg <= gain_range_select_reg;
    end
  end

  // Result registers and read lock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_reg      <= '0;
      result_lock_reg <= 1'b0;
    end else begin
      if (rd_low) begin
        result_lock_reg <= 1'b1;
      end else if (rd_high) begin
        result_lock_reg <= 1'b0;
      end
      // A locked pair keeps its old contents; the new result is lost.
      // A low-byte read in the completion cycle locks as well, so the
      // pair handed out never mixes two conversions.
      if (done_evt && !result_lock_reg && !rd_low) begin
        result_reg <= core_rsp.result;
      end
    end
  end

  // Done flag: write one clears, a completion in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conversion_done_flag_reg <= 1'b0;
      conversion_irq           <= 1'b0;
    end else begin
      if (done_evt) begin
        conversion_done_flag_reg <= 1'b1;
      end else if (wr_ca && wd[adcctl_pkg::CA_DONE]) begin
        conversion_done_flag_reg <= 1'b0;
      end
      conversion_irq <= conversion_done_flag_reg && irq_enable_reg;
    end
  end

  // Core request; selections reach the core only while enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_req <= '0;
    end else begin
      core_req.enable      <= converter_enable_reg;
      core_req.clk_tick    <= tick;
      core_req.start       <= (state_reg == adcctl_pkg::ST_PENDING) && tick;
      core_req.first       <= first_reg;
      core_req.sample_end  <= (state_reg == adcctl_pkg::ST_CONVERT) && tick
                              && (cycle_reg == conv_len);
      core_req.reference   <= converter_enable_reg ? ref_live_reg
                                                   : 3'h0;
      core_req.channel     <= converter_enable_reg ? ch_live_reg
                                                   : 6'h00;
      core_req.gain_range  <= converter_enable_reg && gain_live_reg;
      // Bypass flag stays low while the core is unpowered
      core_req.gain_bypass <= converter_enable_reg
                              && ((ch_live_reg <= adcctl_pkg::CH_SINGLE_MAX)
                              || (ch_live_reg == adcctl_pkg::CH_TEMP));
      core_req.temp_sensor <= converter_enable_reg
                              && (ch_live_reg == adcctl_pkg::CH_TEMP);
    end
  end

endmodule

// File: dv/adcctl_checker.sv
// Concurrent checks on the converter control ports
`timescale 1ns/1ps
module adcctl_checker (
  // Clock and reset
  input wire logic                         hclk,
  input wire logic                         hresetn,
  // Bus
  input wire logic                         hsel,
  input wire logic [9:0]                   haddr,
  input wire logic [1:0]                   htrans,
  input wire logic                         hwrite,
  input wire logic [31:0]                  hwdata,
  input wire logic                         hready,
  input wire logic [31:0]                  hrdata,
  // Core link and pins
  input wire adcctl_pkg::adcctl_core_req_t core_req,
  input wire adcctl_pkg::adcctl_core_rsp_t core_rsp,
  input wire logic [3:0]                   pin_buffer_off_bits,
  input wire logic                         conversion_irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic       rd_q;
  logic       dis_q;
  logic [7:0] rd_idx;
  logic [3:0] dis_exp;

  // Data phase of each taken transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q   <= 1'b0;
      dis_q  <= 1'b0;
      rd_idx <= 8'h00;
    end else begin
      rd_q   <= hsel && hready && htrans == adcctl_pkg::HTRANS_NONSEQ
                && !hwrite;
      dis_q  <= hsel && hready && htrans == adcctl_pkg::HTRANS_NONSEQ
                && hwrite && haddr[9:2] == adcctl_pkg::IDX_INPUT_DISABLE;
      rd_idx <= haddr[9:2];
    end
  end

  // Write data stands only in the data phase, so keep it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dis_exp <= 4'h0;
    end else if (dis_q) begin
      dis_exp <= hwdata[7:4];
    end
  end

  sequence s_sel_hold;
    (core_req.enable && $stable(core_req.channel)
     && $stable(core_req.reference)) [*8];
  endsequence

  sequence s_no_end;
    !core_req.sample_end [*8];
  endsequence

  AST_START_PULSE: assert property (
    core_req.start |=> !core_req.start)
    else $error("start pulse longer than one cycle");
  AST_SEL_FROZEN: assert property (
    core_req.start |=> s_sel_hold)
    else $error("selections moved during conversion");
  AST_NO_EARLY_END: assert property (
    core_req.start |=> s_no_end)
    else $error("conversion ended too early");
  AST_OFF_IDLE: assert property (
    !core_req.enable && !$past(core_req.enable)
    |-> core_req.reference == 3'b000 && core_req.channel == 6'h00
        && !core_req.clk_tick && !core_req.start && !core_req.temp_sensor)
    else $error("converter active while disabled");
  AST_TEMP_SEL: assert property (
    core_req.start
    |-> core_req.temp_sensor == (core_req.channel == adcctl_pkg::CH_TEMP))
    else $error("temperature sensor routing wrong");
  AST_GAIN_BYPASS: assert property (
    core_req.start |-> core_req.gain_bypass
      == (core_req.channel <= adcctl_pkg::CH_SINGLE_MAX
          || core_req.channel == adcctl_pkg::CH_TEMP))
    else $error("gain bypass wrong for channel");
  AST_IRQ_AFTER_DONE: assert property (
    $rose(conversion_irq) |-> $past(core_rsp.done, 2))
    else $error("interrupt without completion");
  AST_DIS_COPY: assert property (
    dis_q |-> ##2 pin_buffer_off_bits == dis_exp)
    else $error("buffer off bits do not follow register");
  AST_RSVD_ZERO: assert property (
    rd_q && rd_idx == adcctl_pkg::IDX_INPUT_DISABLE
    |-> hrdata[3:0] == 4'h0 && hrdata[31:8] == '0)
    else $error("reserved disable bits not zero");
endmodule

bind adcctl_top adcctl_checker u_adcctl_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .core_req(core_req), .core_rsp(core_rsp),
  .pin_buffer_off_bits(pin_buffer_off_bits),
  .conversion_irq(conversion_irq)
);

// File: dv/adcctl_core_model.sv
// Behavioural model of the analog converter core
`timescale 1ns/1ps
module adcctl_core_model (
  // Clock and reset
  input wire logic                         hclk,
  input wire logic                         hresetn,
  // Control link
  input wire adcctl_pkg::adcctl_core_req_t req,
  output adcctl_pkg::adcctl_core_rsp_t     rsp,
  // Test controls
  input wire logic [9:0]                   code,
  input wire logic [3:0]                   lag
);
  logic [4:0] wait_cnt;

  // Answer comes lag + 2 cycles after the last converter cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_cnt <= 5'h00;
      rsp <= '0;
    end else begin
      rsp.done <= 1'b0;
      // Result is not held outside the strobe
      rsp.result <= ~rsp.result;
      if (!req.enable) begin
        wait_cnt <= 5'h00;
      end else if (req.sample_end) begin
        wait_cnt <= {1'b0, lag} + 5'h01;
      end else if (wait_cnt != 5'h00) begin
        wait_cnt <= wait_cnt - 5'h01;
      end
      if (wait_cnt == 5'h01 && req.enable) begin
        rsp.done <= 1'b1;
        rsp.result <= code;
      end
    end
  end
endmodule

// File: dv/tb_adcctl_top.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    cmp_count++; \
    if ((a) !== (e)) begin \
      miscompares++; \
      $display("ERROR %0t: got %h exp %h", $time, (a), (e)); \
    end \
  end
module tb_adcctl_top;
  logic                         hclk, hresetn, hsel, hwrite, hreadyout;
  logic                         hresp, conversion_irq, rd_dph;
  wire logic                    hready;
  logic [9:0]                   haddr, code;
  logic [1:0]                   htrans;
  logic [2:0]                   hsize;
  logic [31:0]                  hwdata, hrdata, exp_w;
  logic [3:0]                   pin_level, pin_buffer_off_bits, lag;
  adcctl_pkg::adcctl_core_req_t core_req;
  adcctl_pkg::adcctl_core_rsp_t core_rsp;
  logic [31:0]                  exp_q[$];
  int                           miscompares, cmp_count, cyc, se_cnt, se_last;

  assign hready = hreadyout;

  adcctl_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .core_req(core_req), .core_rsp(core_rsp),
    .pin_level(pin_level), .pin_buffer_off_bits(pin_buffer_off_bits),
    .conversion_irq(conversion_irq)
  );

  adcctl_core_model core (
    .hclk(hclk), .hresetn(hresetn), .req(core_req), .rsp(core_rsp),
    .code(code), .lag(lag)
  );

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // Cycles from start to last converter cycle
  always @(negedge hclk) begin
    se_cnt++;
    if (core_req.start === 1'b1) se_cnt = 0;
    if (core_req.sample_end === 1'b1) se_last = se_cnt;
  end

  // Read data is taken at the edge that ends the data phase
  always @(posedge hclk) begin
    if (rd_dph === 1'b1 && exp_q.size() > 0) begin
      exp_w = exp_q.pop_front();
      `CHK(hrdata, exp_w)
    end
    rd_dph <= hsel && hready && htrans == adcctl_pkg::HTRANS_NONSEQ
              && !hwrite;
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= adcctl_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {idx, 2'b00};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    `CHK(hresp, adcctl_pkg::HRESP_OKAY)
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h00_0000, e});
    xfer(1'b0, idx, 8'($urandom));
  endtask

  task automatic convert(input logic [2:0] rf, input logic [5:0] ch,
                         input logic lf, input logic g,
                         input logic [9:0] cv, input int p, input int n);
    xfer(1'b1, 8'h07, {rf[1:0], lf, ch[4:0]});
    xfer(1'b1, 8'h03, {1'b0, g, 1'b0, rf[2], ch[5], 3'b000});
    code <= cv;
    lag <= 4'($urandom);
    xfer(1'b1, 8'h06, 8'hC8 | 8'(p));
    for (int k = 0; k < 600 && core_req.start !== 1'b1; k++) @(negedge hclk);
    `CHK(core_req.reference, rf)
    `CHK(core_req.channel, ch)
    `CHK(core_req.gain_range, g)
    `CHK(core_req.temp_sensor, ch == 6'h3F)
    `CHK(core_req.first, n == 25)
    @(posedge hclk);
    rd(8'h06, 8'hC8 | 8'(p));
    for (int k = 0; k < 600 && conversion_irq !== 1'b1; k++) @(negedge hclk);
    `CHK(conversion_irq, 1'b1)
    `CHK(se_last, n * (2 << p))
    @(posedge hclk);
    rd(8'h06, 8'h98 | 8'(p));
    xfer(1'b1, 8'h06, 8'h98 | 8'(p));
  endtask

  initial begin
    logic [3:0] dis;
    logic [5:0] ch;
    logic [9:0] val, prev, src;
    logic       left;
    void'($urandom(32'h5a8a_2e69));
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 10'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    pin_level = 4'h0;
    code = 10'h000;
    lag = 4'h0;
    val = 10'h000;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h02, 8'h00);
    `CHK(pin_buffer_off_bits, 4'h0)
    xfer(1'b1, 8'h02, 8'hFF);
    rd(8'h02, 8'hF0);
    `CHK(pin_buffer_off_bits, 4'hF)
    for (int i = 0; i < 4; i++) begin
      dis = 4'($urandom);
      pin_level <= 4'($urandom);
      xfer(1'b1, 8'h02, {dis, 4'h0});
      repeat (3) @(posedge hclk);
      rd(8'h09, {pin_level & ~dis, 4'h0});
    end
    // Unmapped place reads zero and ignores writes
    xfer(1'b1, 8'h3F, 8'hFF);
    rd(8'h3F, 8'h00);
    // Case 4 reads low only, so case 5 completes while locked
    for (int i = 0; i < 7; i++) begin
      ch = (i == 0) ? 6'h3F : (i == 2) ? 6'h12 : (i == 3) ? 6'h2B
           : 6'($urandom_range(10));
      left = (i < 4) ? i[0] : 1'b0;
      prev = val;
      val = 10'($urandom);
      src = (i == 5) ? prev : val;
      if (i == 2) xfer(1'b1, 8'h06, 8'h00);
      convert(3'($urandom), ch, left, i[1], val, i % 2,
              (i == 0 || i == 2) ? 25 : 13);
      if (i != 5) rd(8'h04, left ? {val[1:0], 6'h00} : val[7:0]);
      if (i != 4) rd(8'h05, left ? src[9:2] : {6'h00, src[9:8]});
    end
    `CHK(conversion_irq, 1'b0)
    stop_test();
  end
endmodule
